// file: hw/clock_select_pkg.sv
// Constants, types and helpers for the system clock select and divider.
// Assumes one 125 MHz clock and oscillators seen as one-cycle ticks.
package clock_select_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CLOCK_SELECT_ADDR     = 8'hA9;
  localparam logic [7:0] EXT_OSC_CONTROL_ADDR  = 8'hB1;
  localparam logic [7:0] CLOCK_SELECT_RESET    = 8'h34;
  localparam logic [7:0] EXT_OSC_CONTROL_RESET = 8'h00;
  localparam int         READY_BIT             = 7;
  localparam int         DIV_LSB               = 4;
  localparam int         SRC_LSB               = 0;
  localparam int         EXT_VALID_BIT         = 7;
  localparam int         EXT_MODE_LSB          = 4;
  localparam int         DRIVE_LSB             = 0;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [2:0] SRC_CODE_PRECISION = 3'h0;
  localparam logic [2:0] SRC_CODE_EXTERNAL  = 3'h1;
  localparam logic [2:0] SRC_CODE_RTC       = 3'h3;
  localparam logic [2:0] MODE_CMOS          = 3'h2;
  localparam logic [2:0] MODE_CMOS_DIV2     = 3'h3;
  localparam logic [2:0] MODE_RC            = 3'h4;
  localparam logic [2:0] MODE_CAP           = 3'h5;
  localparam logic [2:0] MODE_XTAL_DIV2     = 3'h6;
  localparam logic [6:0] TICK_WRAP          = 7'h7F;
  localparam int         SWITCH_TICKS_MAX   = 128;

  typedef enum logic [1:0] {
    SRC_PRECISION, SRC_EXTERNAL, SRC_RTC, SRC_LOW_POWER
  } source_type;

  typedef enum logic {SW_IDLE, SW_WAIT} switch_state_type;

  typedef struct packed {
    source_type source;
    logic [2:0] divideCode;
    logic       dividerApplied;
  } sysclk_status_type;

  typedef struct packed {
    logic       enable;
    logic [2:0] modeCode;
    logic [2:0] driveLevel;
    logic       pinBDigital;
  } ext_osc_drive_type;

  // ****************************************
  // helpers
  // ****************************************
  function automatic source_type sourceOf(input logic [2:0] code,
                                          input source_type cur);
    source_type s;
    s = cur;
    if (code[2])
      s = SRC_LOW_POWER;
    else if (code == SRC_CODE_PRECISION)
      s = SRC_PRECISION;
    else if (code == SRC_CODE_EXTERNAL)
      s = SRC_EXTERNAL;
    else if (code == SRC_CODE_RTC)
      s = SRC_RTC;
    return s;
  endfunction

  function automatic logic [6:0] divMask(input logic [2:0] code);
    logic [7:0] m;
    m = (8'h01 << code) - 8'h01;
    return m[6:0];
  endfunction

  function automatic logic validCapable(input logic [2:0] mode);
    return mode == MODE_RC || mode == MODE_CAP || mode == MODE_XTAL_DIV2;
  endfunction

endpackage

// file: hw/system_clock_select_divider.sv
// System clock source select, power-of-two divider, external osc control.
// Assumes synchronous register port and one-cycle oscillator tick inputs.
//
// Operation
// R1: software picks drive level code whose band covers the target frequency.
// R2: RC start: pin analog, enable oscillator, poll valid, then switch source.
// R3: capacitor mode starts with the same sequence as RC mode.
// R4: valid flag always reads zero in either CMOS clock input mode.
// R5: CMOS clock drives pin b as digital input; pin a unused.
// R6: new divide setting takes effect within 128 undivided source cycles.
// R7: divider applied flag reads 0 while pending, 1 once applied.
// R8: divide field bits 6:4 divides source by two to the code.
// R9: source field bits 2:0: 000, 001, 010 reserved, 011, 1xx.
// R10: source change takes effect after a full period of slower oscillator.
// R11: software sets divide by 1 before suspend or sleep.
// R12: bit 3 of clock select reads 0; software writes 0.
// R13: clock select register answers at 0xA9 on every page.
// R14: software bypasses flash one-shot above 10 MHz.
// R15: reset selects low power oscillator, divide by 8, flag 0.
// R16: mode field decodes disabled, CMOS, CMOS/2, RC, capacitor, crystal/2.
// R17: valid flag is 1 only when external oscillator runs and is stable.
// R18: slower: divider, poll, source; faster: source, divider, poll.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module system_clock_select_divider (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  // register port
  input  wire logic [7:0]                           addr,
  input  wire logic [7:0]                           wrData,
  input  wire logic                                 wrStrobe,
  input  wire logic                                 rdStrobe,
  output logic [7:0]                                rdData,
  // oscillator ticks, indexed by source
  input  wire logic [3:0]                           oscTick,
  input  wire logic                                 extOscStable,
  // system clock and oscillator control
  output logic                                      sysclkTick,
  output clock_select_pkg::sysclk_status_type       status,
  output clock_select_pkg::ext_osc_drive_type       extDrive
);

  // ****************************************
  // registers and bus
  // ****************************************
  logic [2:0]                       srcCode;
  logic [2:0]                       next_srcCode;
  logic [2:0]                       divideReq;
  logic [2:0]                       next_divideReq;
  logic [2:0]                       extMode;
  logic [2:0]                       next_extMode;
  logic [2:0]                       extLevel;
  logic [2:0]                       next_extLevel;
  logic [7:0]                       next_rdData;
  logic                             wrSel;
  logic                             wrExt;
  logic                             extValid;
  logic [2:0]                       divideCur;
  logic                             divPending;
  clock_select_pkg::source_type     activeSrc;

  assign wrSel = wrStrobe && addr == clock_select_pkg::CLOCK_SELECT_ADDR;
  assign wrExt = wrStrobe && addr == clock_select_pkg::EXT_OSC_CONTROL_ADDR;
  // CMOS modes never report valid
  assign extValid = extOscStable &&
                    clock_select_pkg::validCapable(extMode); // R4 R17

  always_comb begin
    next_srcCode   = srcCode;
    next_divideReq = divideReq;
    next_extMode   = extMode;
    next_extLevel  = extLevel;
    next_rdData    = 8'h00;
    // no page input: decode by address alone
    if (wrSel) begin // R13
      next_srcCode   = wrData[clock_select_pkg::SRC_LSB +: 3]; // R9
      next_divideReq = wrData[clock_select_pkg::DIV_LSB +: 3]; // R8
    end
    if (wrExt) begin
      next_extMode  = wrData[clock_select_pkg::EXT_MODE_LSB +: 3];
      next_extLevel = wrData[clock_select_pkg::DRIVE_LSB +: 3];
    end
    if (rdStrobe && addr == clock_select_pkg::CLOCK_SELECT_ADDR) begin
      // bit 3 left zero
      next_rdData[clock_select_pkg::READY_BIT] = !divPending; // R7 R12
      next_rdData[clock_select_pkg::DIV_LSB +: 3] = divideReq;
      next_rdData[clock_select_pkg::SRC_LSB +: 3] = srcCode;
    end else if (rdStrobe &&
                 addr == clock_select_pkg::EXT_OSC_CONTROL_ADDR) begin
      next_rdData[clock_select_pkg::EXT_VALID_BIT]     = extValid;
      next_rdData[clock_select_pkg::EXT_MODE_LSB +: 3] = extMode;
      next_rdData[clock_select_pkg::DRIVE_LSB +: 3]    = extLevel;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srcCode   <= clock_select_pkg::CLOCK_SELECT_RESET[2:0]; // R15
      divideReq <= clock_select_pkg::CLOCK_SELECT_RESET[6:4]; // R15
      extMode   <= clock_select_pkg::EXT_OSC_CONTROL_RESET[6:4];
      extLevel  <= clock_select_pkg::EXT_OSC_CONTROL_RESET[2:0];
      rdData    <= 8'h00;
    end else begin
      srcCode   <= next_srcCode;
      divideReq <= next_divideReq;
      extMode   <= next_extMode;
      extLevel  <= next_extLevel;
      rdData    <= next_rdData;
    end
  end

  // ****************************************
  // external oscillator drive
  // ****************************************
  logic                             extHalf;
  logic                             next_extHalf;
  logic                             extDiv2;
  logic [3:0]                       srcTick;
  logic                             undivTick;

  assign extDiv2 = extMode == clock_select_pkg::MODE_CMOS_DIV2 ||
                   extMode == clock_select_pkg::MODE_XTAL_DIV2;

  always_comb begin
    next_extHalf = extHalf;
    if (oscTick[clock_select_pkg::SRC_EXTERNAL])
      next_extHalf = !extHalf;
    // 00x and unlisted 111 keep the circuit off
    extDrive.enable = extMode[2] ? (extMode != 3'h7) : extMode[1]; // R16
    extDrive.modeCode    = extMode;
    extDrive.driveLevel  = extLevel;
    extDrive.pinBDigital = extMode == clock_select_pkg::MODE_CMOS ||
                           extMode == clock_select_pkg::MODE_CMOS_DIV2;
    srcTick = oscTick;
    srcTick[clock_select_pkg::SRC_EXTERNAL] =
      extDrive.enable && oscTick[clock_select_pkg::SRC_EXTERNAL] &&
      (!extDiv2 || extHalf);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      extHalf <= 1'b0;
    else
      extHalf <= next_extHalf;
  end

  assign undivTick = srcTick[activeSrc];

  // ****************************************
  // source switch
  // ****************************************
  clock_select_pkg::switch_state_type swState;
  clock_select_pkg::switch_state_type next_swState;
  clock_select_pkg::source_type       targetSrc;
  clock_select_pkg::source_type       next_targetSrc;
  clock_select_pkg::source_type       next_activeSrc;
  logic                               seenOld;
  logic                               next_seenOld;
  logic                               seenNew;
  logic                               next_seenNew;
  logic                               switchDone;

  assign switchDone = swState == clock_select_pkg::SW_WAIT &&
                      (seenOld || srcTick[activeSrc]) &&
                      (seenNew || srcTick[targetSrc]);

  always_comb begin
    next_swState   = swState;
    next_targetSrc = targetSrc;
    next_activeSrc = activeSrc;
    next_seenOld   = seenOld || srcTick[activeSrc];
    next_seenNew   = seenNew || srcTick[targetSrc];
    unique case (swState)
      clock_select_pkg::SW_IDLE: begin
        next_seenOld = 1'b0;
        next_seenNew = 1'b0;
      end
      clock_select_pkg::SW_WAIT: begin
        // both clocks run a full period before the hand-over
        if (switchDone) begin // R10
          next_activeSrc = targetSrc;
          next_swState   = clock_select_pkg::SW_IDLE;
        end
      end
    endcase
    if (wrSel) begin
      // reserved code keeps the current target
      next_targetSrc = clock_select_pkg::sourceOf(
                         wrData[clock_select_pkg::SRC_LSB +: 3],
                         next_targetSrc); // R9
      next_seenOld = 1'b0;
      next_seenNew = 1'b0;
      next_swState = next_targetSrc == next_activeSrc ?
                     clock_select_pkg::SW_IDLE : clock_select_pkg::SW_WAIT;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swState   <= clock_select_pkg::SW_IDLE;
      targetSrc <= clock_select_pkg::SRC_LOW_POWER; // R15
      activeSrc <= clock_select_pkg::SRC_LOW_POWER; // R15
      seenOld   <= 1'b0;
      seenNew   <= 1'b0;
    end else begin
      swState   <= next_swState;
      targetSrc <= next_targetSrc;
      activeSrc <= next_activeSrc;
      seenOld   <= next_seenOld;
      seenNew   <= next_seenNew;
    end
  end

  // ****************************************
  // divider
  // ****************************************
  logic [6:0]                       tickCnt;
  logic [6:0]                       next_tickCnt;
  logic [2:0]                       next_divideCur;
  logic                             next_divPending;
  logic                             next_sysclkTick;
  logic                             divEdge;

  assign divEdge = (tickCnt & clock_select_pkg::divMask(divideCur)) ==
                   clock_select_pkg::divMask(divideCur);

  always_comb begin
    next_tickCnt    = undivTick ? tickCnt + 7'h01 : tickCnt;
    next_divideCur  = divideCur;
    next_divPending = divPending;
    next_sysclkTick = undivTick && divEdge; // R8
    // apply only at the 128-tick boundary
    if (divPending && undivTick &&
        tickCnt == clock_select_pkg::TICK_WRAP) begin // R6
      next_divideCur  = divideReq;
      next_divPending = 1'b0;
    end
    if (wrSel)
      next_divPending = 1'b1; // R7
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt    <= 7'h00;
      divideCur  <= clock_select_pkg::CLOCK_SELECT_RESET[6:4];
      divPending <= 1'b1; // R15
      sysclkTick <= 1'b0;
    end else begin
      tickCnt    <= next_tickCnt;
      divideCur  <= next_divideCur;
      divPending <= next_divPending;
      sysclkTick <= next_sysclkTick;
    end
  end

  assign status.source         = activeSrc;
  assign status.divideCode     = divideCur;
  assign status.dividerApplied = !divPending;

  // ****************************************
  // assertions
  // ****************************************
  logic [7:0] pendTicks;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      pendTicks <= 8'h00;
    else if (!divPending || wrSel)
      pendTicks <= 8'h00;
    else if (undivTick)
      pendTicks <= pendTicks + 8'h01;
  end

  sequence s_waitBoth;
    swState == clock_select_pkg::SW_WAIT &&
    (seenOld || srcTick[activeSrc]) && (seenNew || srcTick[targetSrc]);
  endsequence

  property p_cmosInvalid;
    @(posedge clk) disable iff (!rstn)
      (extMode == clock_select_pkg::MODE_CMOS ||
       extMode == clock_select_pkg::MODE_CMOS_DIV2) &&
      rdStrobe && addr == clock_select_pkg::EXT_OSC_CONTROL_ADDR
      |=> !rdData[7];
  endproperty
  a_cmosInvalid: assert property (p_cmosInvalid) // R4
    else $error("valid flag set in CMOS mode");

  property p_divBound;
    @(posedge clk) disable iff (!rstn)
      pendTicks <= clock_select_pkg::SWITCH_TICKS_MAX;
  endproperty
  a_divBound: assert property (p_divBound) // R6
    else $error("divide change took over 128 source cycles");

  property p_pendAfterWrite;
    @(posedge clk) disable iff (!rstn)
      wrSel ##1 !undivTick ##1
      (rdStrobe && addr == clock_select_pkg::CLOCK_SELECT_ADDR)
      |=> !rdData[7];
  endproperty
  a_pendAfterWrite: assert property (p_pendAfterWrite) // R7
    else $error("ready flag high right after divide write");

  property p_divTick;
    @(posedge clk) disable iff (!rstn)
      sysclkTick |-> $past(undivTick) &&
      ($past(tickCnt) & clock_select_pkg::divMask($past(divideCur))) ==
      clock_select_pkg::divMask($past(divideCur));
  endproperty
  a_divTick: assert property (p_divTick) // R8
    else $error("system tick off its divide boundary");

  property p_rtcSelect;
    @(posedge clk) disable iff (!rstn)
      wrSel && wrData[2:0] == clock_select_pkg::SRC_CODE_RTC
      |=> targetSrc == clock_select_pkg::SRC_RTC;
  endproperty
  a_rtcSelect: assert property (p_rtcSelect) // R9
    else $error("code 011 did not target the rtc oscillator");

  property p_switchAfterPeriods;
    @(posedge clk) disable iff (!rstn)
      $changed(activeSrc) |-> $past(switchDone);
  endproperty
  a_switchAfterPeriods: assert property (p_switchAfterPeriods) // R10
    else $error("source switched before both periods elapsed");

  property p_bothSeenSwitch;
    @(posedge clk) disable iff (!rstn)
      s_waitBoth and !wrSel |=> swState == clock_select_pkg::SW_IDLE &&
      activeSrc == $past(targetSrc);
  endproperty
  a_bothSeenSwitch: assert property (p_bothSeenSwitch) // R10
    else $error("switch stalled after both periods");

  property p_bit3Zero;
    @(posedge clk) disable iff (!rstn)
      rdStrobe && addr == clock_select_pkg::CLOCK_SELECT_ADDR
      |=> rdData[3] == 1'b0;
  endproperty
  a_bit3Zero: assert property (p_bit3Zero) // R12
    else $error("clock select bit 3 read as one");

  property p_selWrite;
    @(posedge clk) disable iff (!rstn)
      wrSel |=> srcCode == $past(wrData[2:0]) &&
                divideReq == $past(wrData[6:4]);
  endproperty
  a_selWrite: assert property (p_selWrite) // R13
    else $error("clock select write not stored");

  property p_resetState;
    @(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> divideCur == 3'h3 && divPending &&
      activeSrc == clock_select_pkg::SRC_LOW_POWER;
  endproperty
  a_resetState: assert property (p_resetState) // R15
    else $error("wrong state after reset");

  property p_modeDecode;
    @(posedge clk) disable iff (!rstn)
      extDrive.enable == (extMode inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6});
  endproperty
  a_modeDecode: assert property (p_modeDecode) // R16
    else $error("mode field decode wrong");

  property p_validStable;
    @(posedge clk) disable iff (!rstn)
      rdStrobe && addr == clock_select_pkg::EXT_OSC_CONTROL_ADDR &&
      !extOscStable |=> !rdData[7];
  endproperty
  a_validStable: assert property (p_validStable) // R17
    else $error("valid flag set while oscillator unstable");

endmodule

`default_nettype wire

// file: bench/system_clock_select_divider_bench.sv
// Self-checking bench for the system clock select and divider block.
// Assumes the design package is compiled first; the bench drives every input port.
`timescale 1ns/1ps
`default_nettype none

module system_clock_select_divider_bench;

  // ****************************************
  // signals
  // ****************************************
  logic                                clk          = 1'b0;
  logic                                rstn         = 1'b0;
  logic [7:0]                          addr         = 8'h00;
  logic [7:0]                          wrData       = 8'h00;
  logic                                wrStrobe     = 1'b0;
  logic                                rdStrobe     = 1'b0;
  logic [7:0]                          rdData;
  logic [3:0]                          oscTick      = 4'h0;
  logic                                extOscStable = 1'b0;
  logic                                sysclkTick;
  clock_select_pkg::sysclk_status_type status;
  clock_select_pkg::ext_osc_drive_type extDrive;
  int                                  nFail        = 0;
  int                                  checkCount   = 0;
  int                                  pulses       = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (sysclkTick === 1'b1) pulses <= pulses + 1;
  system_clock_select_divider uut (
    .clk          (clk),
    .rstn         (rstn),
    .addr         (addr),
    .wrData       (wrData),
    .wrStrobe     (wrStrobe),
    .rdStrobe     (rdStrobe),
    .rdData       (rdData),
    .oscTick      (oscTick),
    .extOscStable (extOscStable),
    .sysclkTick   (sysclkTick),
    .status       (status),
    .extDrive     (extDrive)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      nFail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic tick(input int idx);
    @(posedge clk);
    oscTick <= 4'h1 << idx;
    @(posedge clk);
    oscTick <= 4'h0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    logic [7:0] d;
    #1;
    chk("status.source", 8'h03, {6'h00, status.source});
    chk("status.divideCode", 8'h03, {5'h00, status.divideCode});
    chk("status.ready", 8'h00, {7'h00, status.dividerApplied});
    rd(8'hA9, d);
    chk("select reset value", 8'h34, d);
    rd(8'hB1, d);
    chk("ext osc reset value", 8'h00, d);
    wr(8'h10, 8'hFF);
    rd(8'h10, d);
    chk("unmapped read", 8'h00, d);
    rd(8'hA9, d);
    chk("select after unmapped", 8'h34, d);
  endtask
  task automatic test_divider();
    logic [7:0] d;
    int         n;
    for (int c = 7; c >= 0; c--) begin
      wr(8'hA9, {1'b1, c[2:0], 4'h4});
      #1;
      chk("ready after write", 8'h00, {7'h00, status.dividerApplied});
      rd(8'hA9, d);
      chk("pending readback", {1'b0, c[2:0], 4'h4}, d);
      n = 0;
      while (status.dividerApplied !== 1'b1 && n < 130) begin
        tick(3);
        @(posedge clk);
        #1;
        n++;
      end
      chk("ticks to apply", 8'h01, {7'h00, n <= 128});
      chk("divideCode", {5'h00, c[2:0]}, {5'h00, status.divideCode});
      rd(8'hA9, d);
      chk("applied readback", {1'b1, c[2:0], 4'h4}, d);
      n = pulses;
      repeat (128) tick(3);
      repeat (2) @(posedge clk);
      #1;
      chk("sysclk pulses", 8'(128 >> c), 8'(pulses - n));
    end
  endtask
  // source index equals tick index in the package enum order
  task automatic src_step(input logic [2:0] code, input int oldIdx,
                          input int newIdx);
    wr(8'hA9, {5'h00, code});
    tick(oldIdx);
    repeat (3) @(posedge clk);
    #1;
    chk("source before new tick", 8'(oldIdx), {6'h00, status.source});
    tick(newIdx);
    @(posedge clk);
    #1;
    chk("source after both ticks", 8'(newIdx), {6'h00, status.source});
  endtask
  task automatic test_source();
    logic [7:0] d;
    extOscStable <= 1'b1;
    wr(8'hB1, 8'h42);
    rd(8'hB1, d);
    chk("valid before switch", 8'hC2, d);
    src_step(3'h0, 3, 0);
    src_step(3'h1, 0, 1);
    src_step(3'h3, 1, 2);
    src_step(3'h6, 2, 3);
    src_step(3'h0, 3, 0);
    src_step(3'h2, 0, 0);
    rd(8'hA9, d);
    chk("reserved code readback", 8'h02, d & 8'h7F);
  endtask
  task automatic test_ext();
    logic [7:0] d;
    logic       en;
    logic       v;
    extOscStable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      en = m >= 2 && m <= 6;
      v = m >= 4 && m <= 6;
      wr(8'hB1, {1'b1, m[2:0], 1'b1, m[2:0]});
      #1;
      chk("extDrive", {1'(m == 2 || m == 3), en, m[2:0], m[2:0]},
          {extDrive.pinBDigital, extDrive.enable, extDrive.modeCode,
           extDrive.driveLevel});
      rd(8'hB1, d);
      chk("ext osc readback", {v, m[2:0], 1'b0, m[2:0]}, d);
    end
    extOscStable <= 1'b0;
    wr(8'hB1, 8'h45);
    rd(8'hB1, d);
    chk("valid while unstable", 8'h45, d);
  endtask
  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_divider();
    test_source();
    test_ext();
    finish_test();
  end

  initial begin
    repeat (50000) @(posedge clk);
    nFail++;
    finish_test();
  end

endmodule

`default_nettype wire
